// ### fsh_consts.vh
`ifndef FSH_CONSTS_VH
`define FSH_CONSTS_VH

// ----------------------------------------
// opcodes
// ----------------------------------------
`define FSH_OP_LATCH_SET 8'h06
`define FSH_OP_LATCH_CLEAR 8'h04
`define FSH_OP_READ_STAT 8'h05
`define FSH_OP_READ_IDENT 8'h9f
`define FSH_OP_READ_CFG 8'h15
`define FSH_OP_WRITE_STAT 8'h01
`define FSH_OP_QPI_ON 8'h35
`define FSH_OP_QPI_OFF 8'hf5
`define FSH_OP_RST_ARM 8'h66
`define FSH_OP_RST 8'h99
`define FSH_OP_SEC_WRITE 8'h2f
`define FSH_OP_PROT_SEL 8'h68
`define FSH_OP_SINGLE_LOCK 8'h36
`define FSH_OP_SINGLE_UNLOCK 8'h39
`define FSH_OP_GANG_LOCK 8'h7e
`define FSH_OP_GANG_UNLOCK 8'h98
`define FSH_OP_PAGE_PROG 8'h02
`define FSH_OP_QUAD_PAGE_PROG 8'h38
`define FSH_OP_CONT_PROG 8'had
`define FSH_OP_SECTOR_ERASE 8'h20
`define FSH_OP_HALF_BLOCK_ERASE 8'h52
`define FSH_OP_BLOCK_ERASE 8'hd8
`define FSH_OP_CHIP_ERASE 8'h60
`define FSH_OP_CHIP_ERASE_ALT 8'hc7
`define FSH_OP_SUSPEND 8'hb0

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define FSH_ST_BUSY 0
`define FSH_ST_LATCH 1
`define FSH_ST_PROT_LO 2
`define FSH_ST_PROT_HI 5
`define FSH_ST_QUAD 6
`define FSH_ST_LOCK 7
`define FSH_CFG_TB 3
`define FSH_CFG_DC 7
`define FSH_STAT_RST 8'h00
`define FSH_CFG_RST 8'h00

// ----------------------------------------
// framing and timing
// ----------------------------------------
`define FSH_SPI_UNITS 4'h8
`define FSH_QPI_UNITS 4'h2
`define FSH_CLK_NS 4
`define FSH_TW_NS 40000

// identity codes: arbitrary neutral values
`define FSH_MAKER_ID 8'h5a
`define FSH_DEVICE_ID 16'h3c17

`endif

// ### fsh_sync.v
`timescale 1ns/1ps

module fsh_sync #(
  parameter WIDTH = 6
) (
  input wire mclk_i,
  input wire reset_i,
  input wire [WIDTH-1:0] d_i,
  output reg [WIDTH-1:0] q_o
);

  reg [WIDTH-1:0] meta_reg;

  // ----------------------------------------
  // two flops, first one read only by second
  // ----------------------------------------
  always @(posedge mclk_i) begin
    if (reset_i) begin
      meta_reg <= {WIDTH{1'b1}};
      q_o <= {WIDTH{1'b1}};
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end

endmodule

// ### fsh_byte_tx.v
`timescale 1ns/1ps
`include "fsh_consts.vh"

module fsh_byte_tx (
  input wire mclk_i,
  input wire reset_i,
  input wire load_i,
  input wire [7:0] byte_i,
  input wire quad_i,
  input wire step_i,
  output wire [3:0] bits_o,
  output wire last_o
);

  reg [7:0] sh_reg;
  reg [3:0] left_reg;

  // msb first: one bit on one line, or a nibble on four
  assign bits_o = quad_i ? sh_reg[7:4] : {3'b000, sh_reg[7]};
  assign last_o = (left_reg == 4'h1);

  always @(posedge mclk_i) begin
    if (reset_i) begin
      sh_reg <= 8'h00;
      left_reg <= 4'h0;
    end else if (load_i) begin
      sh_reg <= byte_i;
      left_reg <= quad_i ? `FSH_QPI_UNITS : `FSH_SPI_UNITS;
    end else if (step_i) begin
      sh_reg <= quad_i ? {sh_reg[3:0], 4'h0} : {sh_reg[6:0], 1'b0};
      left_reg <= left_reg - 4'h1;
    end
  end

endmodule

// ### fsh_latch_status.v
`timescale 1ns/1ps
`include "fsh_consts.vh"

// How it works
// - latch-set opcode in a frame sets latch
// - content commands need a fresh latch set
// - opcodes as 8 single or 2 quad clocks
// - latch-clear opcode in a frame clears latch
// - latch cleared at reset and content completion
// - ident: 24 bits msb first, spi only
// - ident not decoded while busy
// - status read repeats current byte until deselect
// - configuration read allowed at any time
// - status bit0 shows operation in progress
// - latch clear refuses program, erase, status-write
// - protected program or erase drops latch
// - protect level bits change only by status-write
// - chip erase only with zero protect level
// - quad enable disables write-protect pin
// - lock plus low write-protect rejects status-write
// - otp top/bottom bit, volatile dummy select
// - status-write cycle busy, then clears latch
module fsh_latch_status #(
  parameter [23:0] TW_CYC = (`FSH_TW_NS + `FSH_CLK_NS - 1) / `FSH_CLK_NS,
  parameter [7:0] MAKER_ID = `FSH_MAKER_ID,
  parameter [15:0] DEVICE_ID = `FSH_DEVICE_ID
) (
  input wire mclk_i,
  input wire reset_i,
  input wire cs_n_i,
  input wire sclk_i,
  input wire [3:0] sio_i,
  input wire area_protected_i,
  input wire array_busy_i,
  input wire array_done_i,
  output reg [3:0] sio_o,
  output reg [3:0] sio_oe_n_o,
  output reg array_go_o,
  output reg [7:0] array_op_o,
  output reg [3:0] protect_level_bits_o,
  output reg quad_io_enable_o,
  output reg stat_write_lock_o,
  output reg top_bottom_select_o,
  output reg dummy_count_select_o,
  output reg four_line_cmd_mode_o
);

  localparam SEL_STAT = 2'd0;
  localparam SEL_CFG = 2'd1;
  localparam SEL_ID = 2'd2;
  localparam [7:0] STAT_RST = `FSH_STAT_RST, CFG_RST = `FSH_CFG_RST;

  // ----------------------------------------
  // pin sampling and edge detection
  // ----------------------------------------
  wire [5:0] pin_s;
  wire cs_n_s;
  wire sclk_s;
  wire [3:0] sio_s;
  reg sclk_d_reg;
  reg cs_n_d_reg;

  fsh_sync #(.WIDTH(6)) u_sync (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .d_i({cs_n_i, sclk_i, sio_i}),
    .q_o(pin_s)
  );

  assign cs_n_s = pin_s[5];
  assign sclk_s = pin_s[4];
  assign sio_s = pin_s[3:0];

  wire sclk_rise = sclk_s & ~sclk_d_reg & ~cs_n_s;
  wire sclk_fall = ~sclk_s & sclk_d_reg & ~cs_n_s;
  wire cs_fall = ~cs_n_s & cs_n_d_reg;
  wire cs_rise = cs_n_s & ~cs_n_d_reg;

  always @(posedge mclk_i) begin
    if (reset_i) begin
      sclk_d_reg <= 1'b0;
      cs_n_d_reg <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      cs_n_d_reg <= cs_n_s;
    end
  end

  // ----------------------------------------
  // state declarations
  // ----------------------------------------
  reg [7:0] rx_reg;
  reg [3:0] unit_cnt_reg;
  reg [1:0] byte_cnt_reg;
  reg [7:0] op_reg;
  reg [7:0] data0_reg;
  reg [7:0] data1_reg;
  reg frame_quad_reg;
  reg tx_on_reg;
  reg [1:0] tx_sel_reg;
  reg [1:0] id_idx_reg;
  reg write_latch_flag_reg;
  reg wr_busy_reg;
  reg [23:0] tw_cnt_reg;
  reg [5:0] new_stat_reg;
  reg [1:0] new_cfg_reg;
  reg cfg_pend_reg;
  reg rst_armed_reg;

  // ----------------------------------------
  // status and configuration bytes
  // ----------------------------------------
  wire busy = wr_busy_reg | array_busy_i;
  // quad enable or quad framing turns off pin protection
  wire hw_protect_mode = stat_write_lock_o & ~sio_s[2] & ~quad_io_enable_o & ~four_line_cmd_mode_o;
  reg [7:0] flash_status_byte;
  reg [7:0] cfg_byte;

  always @* begin
    flash_status_byte = 8'h00;
    flash_status_byte[`FSH_ST_BUSY] = busy;
    flash_status_byte[`FSH_ST_LATCH] = write_latch_flag_reg;
    flash_status_byte[`FSH_ST_PROT_HI:`FSH_ST_PROT_LO] = protect_level_bits_o;
    flash_status_byte[`FSH_ST_QUAD] = quad_io_enable_o;
    flash_status_byte[`FSH_ST_LOCK] = stat_write_lock_o;
    cfg_byte = 8'h00;
    cfg_byte[`FSH_CFG_TB] = top_bottom_select_o;
    cfg_byte[`FSH_CFG_DC] = dummy_count_select_o;
  end

  function [7:0] tx_byte_f;
    input [1:0] sel;
    input [1:0] idx;
    input [7:0] st;
    input [7:0] cf;
    begin
      if (sel == SEL_STAT) tx_byte_f = st;
      else if (sel == SEL_CFG) tx_byte_f = cf;
      else if (idx == 2'd0) tx_byte_f = MAKER_ID;
      else if (idx == 2'd1) tx_byte_f = DEVICE_ID[15:8];
      else if (idx == 2'd2) tx_byte_f = DEVICE_ID[7:0];
      else tx_byte_f = 8'h00;
    end
  endfunction

  // ----------------------------------------
  // opcode and data collection
  // ----------------------------------------
  // spi takes only line 0, quad takes a nibble
  wire [7:0] rx_next = frame_quad_reg ? {rx_reg[3:0], sio_s} : {rx_reg[6:0], sio_s[0]};
  wire [3:0] units_m1 = (frame_quad_reg ? `FSH_QPI_UNITS : `FSH_SPI_UNITS) - 4'h1;
  wire byte_done = sclk_rise & (unit_cnt_reg == units_m1);
  wire op_done = byte_done & (byte_cnt_reg == 2'd0);

  reg rd_ok;
  reg [1:0] rd_sel;

  always @* begin
    rd_ok = 1'b0;
    rd_sel = SEL_STAT;
    // status read accepted even while busy
    if (rx_next == `FSH_OP_READ_STAT) begin
      rd_ok = 1'b1;
    // configuration read accepted even while busy
    end else if (rx_next == `FSH_OP_READ_CFG) begin
      rd_ok = 1'b1;
      rd_sel = SEL_CFG;
    // ident ignored while busy, single-line only
    end else if (rx_next == `FSH_OP_READ_IDENT && !frame_quad_reg && !busy) begin
      rd_ok = 1'b1;
      rd_sel = SEL_ID;
    end
  end

  // ----------------------------------------
  // reply shifter
  // ----------------------------------------
  wire [3:0] tx_bits;
  wire tx_last;
  wire tx_reload = sclk_fall & tx_on_reg & tx_last;
  wire tx_load = (op_done & rd_ok) | tx_reload;
  wire tx_step = sclk_fall & tx_on_reg & ~tx_last;
  // each reload takes the live status again
  wire [7:0] tx_byte = op_done ? tx_byte_f(rd_sel, 2'd0, flash_status_byte, cfg_byte)
                               : tx_byte_f(tx_sel_reg, id_idx_reg, flash_status_byte, cfg_byte);

  fsh_byte_tx u_tx (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .load_i(tx_load),
    .byte_i(tx_byte),
    .quad_i(frame_quad_reg),
    .step_i(tx_step),
    .bits_o(tx_bits),
    .last_o(tx_last)
  );

  always @(posedge mclk_i) begin
    if (reset_i) begin
      rx_reg <= 8'h00;
      unit_cnt_reg <= 4'h0;
      byte_cnt_reg <= 2'd0;
      op_reg <= 8'h00;
      data0_reg <= 8'h00;
      data1_reg <= 8'h00;
      frame_quad_reg <= 1'b0;
      tx_on_reg <= 1'b0;
      tx_sel_reg <= SEL_STAT;
      id_idx_reg <= 2'd0;
    end else if (cs_fall) begin
      unit_cnt_reg <= 4'h0;
      byte_cnt_reg <= 2'd0;
      op_reg <= 8'h00;
      tx_on_reg <= 1'b0;
      frame_quad_reg <= four_line_cmd_mode_o;
    end else if (cs_n_s) begin
      tx_on_reg <= 1'b0;
    end else if (sclk_rise) begin
      rx_reg <= rx_next;
      if (byte_done) begin
        unit_cnt_reg <= 4'h0;
        if (byte_cnt_reg != 2'd3) begin
          byte_cnt_reg <= byte_cnt_reg + 2'd1;
        end
        case (byte_cnt_reg)
          2'd0: op_reg <= rx_next;
          2'd1: data0_reg <= rx_next;
          2'd2: data1_reg <= rx_next;
          default: ;
        endcase
        // reply armed right after the last opcode bit
        if (op_done && rd_ok) begin
          tx_on_reg <= 1'b1;
          tx_sel_reg <= rd_sel;
          id_idx_reg <= 2'd1;
        end
      end else begin
        unit_cnt_reg <= unit_cnt_reg + 4'h1;
      end
    end else if (tx_reload && tx_sel_reg == SEL_ID && id_idx_reg != 2'd3) begin
      id_idx_reg <= id_idx_reg + 2'd1;
    end
  end

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  always @(posedge mclk_i) begin
    // output stops as soon as select rises
    if (reset_i || cs_n_s) begin
      sio_o <= 4'h0;
      sio_oe_n_o <= 4'hf;
    end else if (sclk_fall && tx_on_reg) begin
      if (frame_quad_reg) begin
        sio_o <= tx_bits;
        sio_oe_n_o <= 4'h0;
      end else begin
        sio_o <= {2'b00, tx_bits[0], 1'b0};
        sio_oe_n_o <= 4'hd;
      end
    end
  end

  // ----------------------------------------
  // end of frame command decode
  // ----------------------------------------
  // single-byte commands must end exactly on a byte boundary
  wire frame_ok = cs_rise & (unit_cnt_reg == 4'h0) & (byte_cnt_reg != 2'd0);
  wire may_change = write_latch_flag_reg & ~busy;
  reg wel_set;
  reg wel_clr;
  reg go;
  reg qpi_set;
  reg qpi_clr;
  reg arm;
  reg soft_rst;
  reg wr_start;

  always @* begin
    wel_set = 1'b0;
    wel_clr = 1'b0;
    go = 1'b0;
    qpi_set = 1'b0;
    qpi_clr = 1'b0;
    arm = 1'b0;
    soft_rst = 1'b0;
    wr_start = 1'b0;
    if (frame_ok) begin
      case (op_reg)
        `FSH_OP_LATCH_SET: wel_set = 1'b1;
        `FSH_OP_LATCH_CLEAR: wel_clr = 1'b1;
        `FSH_OP_QPI_ON: qpi_set = ~busy;
        `FSH_OP_QPI_OFF: qpi_clr = ~busy;
        `FSH_OP_RST_ARM: arm = 1'b1;
        `FSH_OP_RST: begin
          soft_rst = rst_armed_reg;
          wel_clr = rst_armed_reg;
        end
        `FSH_OP_SUSPEND: wel_clr = 1'b1;
        `FSH_OP_WRITE_STAT: wr_start = may_change & ~hw_protect_mode & (byte_cnt_reg >= 2'd2);
        `FSH_OP_PAGE_PROG, `FSH_OP_QUAD_PAGE_PROG, `FSH_OP_CONT_PROG, `FSH_OP_SECTOR_ERASE,
        `FSH_OP_HALF_BLOCK_ERASE, `FSH_OP_BLOCK_ERASE: begin
          if (may_change) begin
            wel_clr = area_protected_i;
            go = ~area_protected_i;
          end
        end
        `FSH_OP_CHIP_ERASE, `FSH_OP_CHIP_ERASE_ALT: begin
          // any protect level blocks chip erase
          if (may_change) begin
            wel_clr = (protect_level_bits_o != 4'h0);
            go = (protect_level_bits_o == 4'h0);
          end
        end
        // latch needed for every content change
        `FSH_OP_SEC_WRITE, `FSH_OP_PROT_SEL, `FSH_OP_SINGLE_LOCK, `FSH_OP_SINGLE_UNLOCK,
        `FSH_OP_GANG_LOCK, `FSH_OP_GANG_UNLOCK: go = may_change;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // status-write cycle
  // ----------------------------------------
  wire wr_done = wr_busy_reg & (tw_cnt_reg == TW_CYC - 24'd1);

  always @(posedge mclk_i) begin
    if (reset_i) begin
      wr_busy_reg <= 1'b0;
      tw_cnt_reg <= 24'h000000;
      new_stat_reg <= 6'h00;
      new_cfg_reg <= 2'b00;
      cfg_pend_reg <= 1'b0;
      protect_level_bits_o <= STAT_RST[`FSH_ST_PROT_HI:`FSH_ST_PROT_LO];
      quad_io_enable_o <= STAT_RST[`FSH_ST_QUAD];
      stat_write_lock_o <= STAT_RST[`FSH_ST_LOCK];
      top_bottom_select_o <= CFG_RST[`FSH_CFG_TB];
      dummy_count_select_o <= CFG_RST[`FSH_CFG_DC];
    end else if (wr_start) begin
      // busy for the whole self-timed cycle
      wr_busy_reg <= 1'b1;
      tw_cnt_reg <= 24'h000000;
      new_stat_reg <= data0_reg[7:2];
      new_cfg_reg <= {data1_reg[`FSH_CFG_DC], data1_reg[`FSH_CFG_TB]};
      cfg_pend_reg <= (byte_cnt_reg == 2'd3);
    end else if (wr_done) begin
      wr_busy_reg <= 1'b0;
      protect_level_bits_o <= new_stat_reg[3:0];
      quad_io_enable_o <= new_stat_reg[4];
      stat_write_lock_o <= new_stat_reg[5];
      if (cfg_pend_reg) begin
        // top/bottom is one-time: it can only be set
        top_bottom_select_o <= top_bottom_select_o | new_cfg_reg[0];
        dummy_count_select_o <= new_cfg_reg[1];
      end
    end else if (wr_busy_reg) begin
      tw_cnt_reg <= tw_cnt_reg + 24'h000001;
    end
  end

  // ----------------------------------------
  // latch, mode and array hand-off
  // ----------------------------------------
  always @(posedge mclk_i) begin
    if (reset_i) begin
      write_latch_flag_reg <= 1'b0;
      four_line_cmd_mode_o <= 1'b0;
      rst_armed_reg <= 1'b0;
      array_go_o <= 1'b0;
      array_op_o <= 8'h00;
    end else begin
      // set wins over any clear landing in the same cycle
      if (wel_set) begin
        write_latch_flag_reg <= 1'b1;
      end else if (wel_clr || wr_done || array_done_i) begin
        write_latch_flag_reg <= 1'b0;
      end
      if (qpi_set) begin
        four_line_cmd_mode_o <= 1'b1;
      end else if (qpi_clr || soft_rst) begin
        four_line_cmd_mode_o <= 1'b0;
      end
      // arming survives only into the very next command frame
      if (frame_ok) begin
        rst_armed_reg <= arm;
      end
      array_go_o <= go;
      if (go) begin
        array_op_o <= op_reg;
      end
    end
  end

endmodule

// ### fsh_host_model.sv
`timescale 1ns/1ps

module fsh_host_model (
  input wire mclk_i,
  input wire [3:0] dev_sio_i,
  input wire [3:0] dev_oe_n_i,
  output logic cs_n_o,
  output logic sclk_o,
  output wire [3:0] pin_o
);
  logic [3:0] drv;
  logic quad_on;
  logic wp_n;
  // shared pins: whoever enables wins, the host inverts lines it has let go
  assign pin_o = (dev_oe_n_i & drv) | (~dev_oe_n_i & dev_sio_i);
  initial begin
    cs_n_o = 1'h1;
    sclk_o = 1'h0;
    drv = 4'h0;
    quad_on = 1'h0;
    wp_n = 1'h1;
  end
  task automatic half;
    repeat (8) @(posedge mclk_i);
  endtask
  // ----------------------------------------
  // one frame: opcode, nw bytes of wd, nr reply bytes
  // ----------------------------------------
  task automatic frame(input logic [7:0] op, input logic [15:0] wd, input int nw, input int nr,
                       output logic [23:0] rd);
    int upb;
    int nin;
    logic [31:0] sh;
    upb = quad_on ? 2 : 8;
    nin = (1 + nw) * upb;
    sh = {op, wd, 8'h00};
    rd = 24'h0;
    @(posedge mclk_i);
    cs_n_o <= 1'h0;
    half();
    // whole bytes inside one select frame
    for (int i = 0; i < nin + nr * upb; i++) begin
      // lines 1 and 3 toggle in single-line mode, line 2 holds wp_n
      if (quad_on) drv <= (i < nin) ? sh[31:28] : ~drv;
      else drv <= {~drv[3], wp_n, ~drv[1], (i < nin) ? sh[31] : ~drv[0]};
      sh = quad_on ? sh << 4 : sh << 1;
      sclk_o <= 1'h0;
      half();
      if (i >= nin) rd = quad_on ? {rd[19:0], pin_o} : {rd[22:0], pin_o[1]};
      sclk_o <= 1'h1;
      half();
    end
    sclk_o <= 1'h0;
    half();
    cs_n_o <= 1'h1;
    repeat (16) @(posedge mclk_i);
  endtask
endmodule

// ### fsh_latch_status_asserts.sv
`timescale 1ns/1ps

module fsh_latch_status_asserts (
  input wire mclk_i,
  input wire reset_i,
  input wire cs_n_i,
  input wire [3:0] sio_oe_n_o,
  input wire array_go_o,
  input wire [3:0] protect_level_bits_o,
  input wire quad_io_enable_o,
  input wire stat_write_lock_o,
  input wire four_line_cmd_mode_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // ----------------------------------------
  // pins
  // ----------------------------------------
  property p_release; $rose(cs_n_i) |-> ##[1:6] (sio_oe_n_o == 4'hf); endproperty
  a_release: assert property (p_release)
    else $error("drivers not released after deselect");
  property p_legal; sio_oe_n_o inside {4'hf, 4'hd, 4'h0}; endproperty
  a_legal: assert property (p_legal)
    else $error("unexpected output enable pattern");
  property p_spi_line; (!four_line_cmd_mode_o && sio_oe_n_o != 4'hf) |-> sio_oe_n_o == 4'hd; endproperty
  a_spi_line: assert property (p_spi_line)
    else $error("single-line reply drives more than one line");
  property p_quad_lines; (four_line_cmd_mode_o && sio_oe_n_o != 4'hf) |-> sio_oe_n_o == 4'h0; endproperty
  a_quad_lines: assert property (p_quad_lines)
    else $error("quad reply not on all four lines");
  // ----------------------------------------
  // commands take effect only after deselect
  // ----------------------------------------
  property p_go_pulse; array_go_o |=> !array_go_o; endproperty
  a_go_pulse: assert property (p_go_pulse)
    else $error("array start longer than one cycle");
  property p_go_deselect; array_go_o |-> cs_n_i && $past(cs_n_i); endproperty
  a_go_deselect: assert property (p_go_deselect)
    else $error("array start while selected");
  property p_nv_idle; $changed({protect_level_bits_o, quad_io_enable_o, stat_write_lock_o}) |-> cs_n_i; endproperty
  a_nv_idle: assert property (p_nv_idle)
    else $error("status bits changed inside a frame");
  property p_mode_idle; $changed(four_line_cmd_mode_o) |-> cs_n_i; endproperty
  a_mode_idle: assert property (p_mode_idle)
    else $error("framing mode changed inside a frame");
  c_go: cover property (array_go_o);
  c_spi_reply: cover property (sio_oe_n_o == 4'hd);
  c_quad_reply: cover property (sio_oe_n_o == 4'h0);
endmodule

// ### fsh_latch_status_test.sv
`timescale 1ns/1ps
`include "fsh_consts.vh"

module fsh_latch_status_test;
  typedef struct packed {logic pre; logic [7:0] op; logic prot; logic [7:0] st; logic go;} fsh_row_t;
  logic mclk_i;
  logic reset_i;
  logic area_protected_i;
  logic array_busy_i;
  logic array_done_i;
  wire cs_n;
  wire sclk;
  wire [3:0] pins;
  wire [3:0] sio_o;
  wire [3:0] sio_oe_n_o;
  wire array_go_o;
  wire [7:0] array_op_o;
  wire [3:0] prot_o;
  wire qe_o, lock_o, tb_o, dc_o, mode_o;
  int bad_count = 0;
  int n_checks = 0;
  int go_cnt = 0;
  int oe_cnt = 0;
  int g0;
  int e0;
  logic [23:0] rd;
  fsh_row_t rows [19] = '{
    '{1'h0, 8'h06, 1'h0, 8'h02, 1'h0}, '{1'h1, 8'h04, 1'h0, 8'h00, 1'h0}, '{1'h0, 8'h02, 1'h0, 8'h00, 1'h0},
    '{1'h1, 8'h02, 1'h1, 8'h00, 1'h0}, '{1'h1, 8'hb0, 1'h0, 8'h00, 1'h0}, '{1'h1, 8'h02, 1'h0, 8'h02, 1'h1},
    '{1'h1, 8'h38, 1'h0, 8'h02, 1'h1}, '{1'h1, 8'had, 1'h0, 8'h02, 1'h1}, '{1'h1, 8'h20, 1'h0, 8'h02, 1'h1},
    '{1'h1, 8'h52, 1'h0, 8'h02, 1'h1}, '{1'h1, 8'hd8, 1'h0, 8'h02, 1'h1}, '{1'h1, 8'h60, 1'h0, 8'h02, 1'h1},
    '{1'h1, 8'hc7, 1'h0, 8'h02, 1'h1}, '{1'h1, 8'h2f, 1'h0, 8'h02, 1'h1}, '{1'h1, 8'h68, 1'h0, 8'h02, 1'h1},
    '{1'h1, 8'h36, 1'h0, 8'h02, 1'h1}, '{1'h1, 8'h39, 1'h0, 8'h02, 1'h1}, '{1'h1, 8'h7e, 1'h0, 8'h02, 1'h1},
    '{1'h1, 8'h98, 1'h0, 8'h02, 1'h1}};

  fsh_host_model i_fsh_host_model (.mclk_i(mclk_i), .dev_sio_i(sio_o), .dev_oe_n_i(sio_oe_n_o),
    .cs_n_o(cs_n), .sclk_o(sclk), .pin_o(pins));
  // status-write cycle shortened to 1000 clocks, still long enough for a read to land inside it
  fsh_latch_status #(.TW_CYC(24'd1000)) i_fsh_latch_status (.mclk_i(mclk_i), .reset_i(reset_i),
    .cs_n_i(cs_n), .sclk_i(sclk), .sio_i(pins), .area_protected_i(area_protected_i),
    .array_busy_i(array_busy_i), .array_done_i(array_done_i), .sio_o(sio_o), .sio_oe_n_o(sio_oe_n_o),
    .array_go_o(array_go_o), .array_op_o(array_op_o), .protect_level_bits_o(prot_o),
    .quad_io_enable_o(qe_o), .stat_write_lock_o(lock_o), .top_bottom_select_o(tb_o),
    .dummy_count_select_o(dc_o), .four_line_cmd_mode_o(mode_o));

  always @(posedge mclk_i) begin
    if (array_go_o === 1'h1) go_cnt <= go_cnt + 1;
    if (sio_oe_n_o !== 4'hf) oe_cnt <= oe_cnt + 1;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic cmd(input logic [7:0] op);
    i_fsh_host_model.frame(op, 16'h0, 0, 0, rd);
  endtask
  task automatic wr_stat(input logic [15:0] wd, input int nw);
    cmd(8'h06);
    i_fsh_host_model.frame(8'h01, wd, nw, 0, rd);
  endtask
  // two bytes back to back must both show the live status
  task automatic stat(input logic [7:0] exp);
    i_fsh_host_model.frame(8'h05, 16'h0, 0, 2, rd);
    check("status", rd, {8'h00, exp, exp});
  endtask
  task automatic done_pulse;
    @(posedge mclk_i);
    array_done_i <= 1'h1;
    @(posedge mclk_i);
    array_done_i <= 1'h0;
    ticks(4);
  endtask

  initial begin
    mclk_i = 1'h0;
    forever #2 mclk_i = ~mclk_i;
  end
  initial begin
    ticks(80000);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    reset_i = 1'h1;
    area_protected_i = 1'h0;
    array_busy_i = 1'h0;
    array_done_i = 1'h0;
    ticks(20);
    reset_i <= 1'h0;
    ticks(4);
    check("reset", {sio_oe_n_o, array_op_o, prot_o, qe_o, lock_o, tb_o, dc_o, mode_o, array_go_o}, 24'h3c0000);
    stat(8'h00);
    foreach (rows[k]) begin
      if (rows[k].pre) cmd(8'h06);
      area_protected_i <= rows[k].prot;
      g0 = go_cnt;
      cmd(rows[k].op);
      check("go", 24'(go_cnt - g0), {23'h0, rows[k].go});
      if (rows[k].go) check("op", {16'h0, array_op_o}, {16'h0, rows[k].op});
      stat(rows[k].st);
      done_pulse();
      stat(8'h00);
    end
    area_protected_i <= 1'h0;
    wr_stat(16'hbc88, 2);
    stat(8'h03);
    e0 = oe_cnt;
    i_fsh_host_model.frame(8'h9f, 16'h0, 0, 1, rd);
    check("ident busy", 24'(oe_cnt - e0), 24'h0);
    ticks(1100);
    stat(8'hbc);
    check("nv bits", {16'h0, prot_o, lock_o, tb_o, dc_o, qe_o}, 24'hfe);
    i_fsh_host_model.frame(8'h15, 16'h0, 0, 1, rd);
    check("config", rd & 24'h88, 24'h88);
    i_fsh_host_model.wp_n = 1'h0;
    wr_stat(16'h0000, 1);
    ticks(1100);
    check("locked", {20'h0, prot_o}, 24'hf);
    cmd(8'h06);
    g0 = go_cnt;
    cmd(8'h60);
    check("chip erase", 24'(go_cnt - g0), 24'h0);
    stat(8'hbc);
    i_fsh_host_model.wp_n = 1'h1;
    wr_stat(16'h0000, 1);
    ticks(1100);
    stat(8'h00);
    // quad enable lifts pin protection; top/bottom cannot be cleared
    wr_stat(16'hc000, 2);
    ticks(1100);
    check("qe lock", {22'h0, qe_o, lock_o}, 24'h3);
    check("otp tb", {22'h0, tb_o, dc_o}, 24'h2);
    i_fsh_host_model.wp_n = 1'h0;
    wr_stat(16'h0000, 1);
    ticks(1100);
    check("qe wp off", {22'h0, qe_o, lock_o}, 24'h0);
    i_fsh_host_model.wp_n = 1'h1;
    array_busy_i <= 1'h1;
    ticks(2);
    stat(8'h01);
    cmd(8'h06);
    g0 = go_cnt;
    cmd(8'h02);
    check("busy prog", 24'(go_cnt - g0), 24'h0);
    stat(8'h03);
    array_busy_i <= 1'h0;
    done_pulse();
    i_fsh_host_model.frame(8'h9f, 16'h0, 0, 3, rd);
    check("ident", rd, {`FSH_MAKER_ID, `FSH_DEVICE_ID});
    cmd(8'h35);
    check("quad on", {23'h0, mode_o}, 24'h1);
    i_fsh_host_model.quad_on = 1'h1;
    cmd(8'h06);
    stat(8'h02);
    e0 = oe_cnt;
    i_fsh_host_model.frame(8'h9f, 16'h0, 0, 1, rd);
    check("quad ident", 24'(oe_cnt - e0), 24'h0);
    cmd(8'h66);
    cmd(8'h99);
    i_fsh_host_model.quad_on = 1'h0;
    check("soft reset", {23'h0, mode_o}, 24'h0);
    stat(8'h00);
    cmd(8'h35);
    i_fsh_host_model.quad_on = 1'h1;
    cmd(8'hf5);
    i_fsh_host_model.quad_on = 1'h0;
    check("quad off", {23'h0, mode_o}, 24'h0);
    // reset in mid-run must drop the latch
    cmd(8'h06);
    reset_i <= 1'h1;
    ticks(4);
    reset_i <= 1'h0;
    ticks(4);
    stat(8'h00);
    tally_and_finish();
  end
endmodule

bind fsh_latch_status fsh_latch_status_asserts i_fsh_latch_status_asserts (.mclk_i(mclk_i), .reset_i(reset_i),
  .cs_n_i(cs_n_i), .sio_oe_n_o(sio_oe_n_o), .array_go_o(array_go_o), .protect_level_bits_o(protect_level_bits_o),
  .quad_io_enable_o(quad_io_enable_o), .stat_write_lock_o(stat_write_lock_o),
  .four_line_cmd_mode_o(four_line_cmd_mode_o));
